//--- core/usf_uart.sv
// Serial core with in-band flow control, time-out and APB registers
// Operation
// - Reset clears all four flow characters
// - Double mode matches two consecutive characters
// - Flow characters that pause or resume never enter receive FIFO
// - Send pause when count passes threshold
// - Send resume when count drops below
// - Special detect flags second pause match
// - Compare only programmed word length bits
// - Character bit 0 aligned with LSB
// - Transmit-empty interrupt raised when enabled
// - Status shows only highest pending source
// - Data and time-out share enable bit
// - Data interrupt at trigger count
// - No time-out with empty FIFO
// - Time-out restarts at stop, holding read
// - Time-out equals four character times
// - Divisor from 1 to 65535
// - Rate is clock/(pre*16*(N+M/16))
// - Prescaler 1 or 4 by bit 7
// - One generator clocks both directions
// - Pause halts data transmission, resume releases it
// - High and low thresholds steer sending
`timescale 1ns/100ps
`include "usf_consts.svh"
module usf_uart (
	// Clock, reset, enable
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Serial line and interrupt
	input  wire logic        i_rx,
	output logic             o_tx,
	output logic             o_irq
);
	logic [7:0] ier_reg, lcr_reg, mcr_reg, efr_reg, divlo_reg, divhi_reg;
	logic [3:0] frac_reg;
	logic [7:0] res1_reg, res2_reg, pau1_reg, pau2_reg;
	logic [4:0] flowhi_reg, flowlo_reg, rxtrig_reg;
	logic [7:0] mem [0:15];
	logic [3:0] wptr_reg, rptr_reg;
	logic [4:0] count_reg;
	logic       tick;
	logic       wr_fire, rd_fire, pop, isr_rd;
	logic [7:0] isr_code, mask;
	logic [3:0] nbits;
	// Receiver, plus transmitter shift state
	usf_pkg::usf_ser_state_t rx_st_reg, tx_st_reg;
	logic [3:0] rx_t_reg, tx_t_reg;
	logic [2:0] rx_b_reg, tx_b_reg;
	logic [7:0] rx_sh_reg, rx_char_reg, tx_sh_reg;
	logic       rx_done_reg, replay_reg;
	logic       held_reg, held_on_reg;
	logic [7:0] held_char_reg;
	logic       push, act_pause, act_resume, hold_set, hold_clr, replay;
	logic       spc_hit;
	logic [7:0] push_data;
	logic       m_on1, m_on2, m_off1, m_off2;
	// Transmitter and flow state
	logic [7:0] thr_reg;
	logic       thr_full_reg, thr_pend_reg, paused_reg, spc_flag_reg;
	logic       sent_pause_reg;
	logic [1:0] flow_left_reg;
	logic [5:0] tx_tick_reg, stop_ticks;
	logic [7:0] flow_char;
	logic       tx_start_data, tx_start_flow;
	// Time-out
	logic [9:0] to_cnt_reg, to_limit;
	logic [4:0] half_bits;
	logic       to_flag_reg, to_restart;

	// One rate source for both directions
	usf_baud_gen u_baud (
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_ce      (i_ce),
		.i_divisor ({divhi_reg, divlo_reg}),
		.i_frac    (frac_reg),
		.i_presc4  (mcr_reg[`USF_MCR_PRE]),
		.o_tick16  (tick)
	);

	// Bus strobes; one wait state so read data can be registered
	assign wr_fire = i_psel && i_penable && !o_pready && i_pwrite;
	assign rd_fire = i_psel && i_penable && !o_pready && !i_pwrite;
	assign pop     = rd_fire && i_paddr == `USF_A_DATA && count_reg != 5'h0;
	assign isr_rd  = rd_fire && i_paddr == `USF_A_ISR;

	// Word length mask, LSB aligned
	assign nbits = 4'h5 + {2'h0, lcr_reg[1:0]};
	assign mask  = 8'hff >> (2'h3 - lcr_reg[1:0]);
	assign m_on1  = (rx_char_reg & mask) == (res1_reg & mask);
	assign m_on2  = (rx_char_reg & mask) == (res2_reg & mask);
	assign m_off1 = (rx_char_reg & mask) == (pau1_reg & mask);
	assign m_off2 = (rx_char_reg & mask) == (pau2_reg & mask);

	// Highest pending source only
	always_comb begin
		isr_code = `USF_ISR_NONE;
		if (ier_reg[`USF_IER_RX] && count_reg >= rxtrig_reg) begin
			isr_code = `USF_ISR_RXD;
		end else if (ier_reg[`USF_IER_RX] && to_flag_reg) begin
			isr_code = `USF_ISR_RXTO;
		end else if (ier_reg[`USF_IER_THR] && thr_pend_reg) begin
			isr_code = `USF_ISR_THR;
		end else if (ier_reg[`USF_IER_SPC] && spc_flag_reg) begin
			isr_code = `USF_ISR_SPC;
		end
	end

	// Register writes
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ier_reg    <= 8'h00;
			lcr_reg    <= `USF_RST_LCR;
			mcr_reg    <= 8'h00;
			efr_reg    <= 8'h00;
			divlo_reg  <= `USF_RST_DIVLO;
			divhi_reg  <= `USF_RST_DIVHI;
			frac_reg   <= 4'h0;
			res1_reg   <= `USF_RST_CHAR;
			res2_reg   <= `USF_RST_CHAR;
			pau1_reg   <= `USF_RST_CHAR;
			pau2_reg   <= `USF_RST_CHAR;
			flowhi_reg <= `USF_RST_FLOWHI;
			flowlo_reg <= `USF_RST_FLOWLO;
			rxtrig_reg <= `USF_RST_RXTRIG;
		end else if (i_ce && wr_fire) begin
			case (i_paddr)
				`USF_A_IER:    ier_reg    <= i_pwdata[7:0];
				`USF_A_LCR:    lcr_reg    <= i_pwdata[7:0];
				`USF_A_MCR:    mcr_reg    <= i_pwdata[7:0];
				`USF_A_EFR:    efr_reg    <= i_pwdata[7:0];
				`USF_A_DIVLO:  divlo_reg  <= i_pwdata[7:0];
				`USF_A_DIVHI:  divhi_reg  <= i_pwdata[7:0];
				`USF_A_FRAC:   frac_reg   <= i_pwdata[3:0];
				`USF_A_RES1:   res1_reg   <= i_pwdata[7:0];
				`USF_A_RES2:   res2_reg   <= i_pwdata[7:0];
				`USF_A_PAU1:   pau1_reg   <= i_pwdata[7:0];
				`USF_A_PAU2:   pau2_reg   <= i_pwdata[7:0];
				`USF_A_FLOWHI: flowhi_reg <= i_pwdata[4:0];
				`USF_A_FLOWLO: flowlo_reg <= i_pwdata[4:0];
				`USF_A_RXTRIG: rxtrig_reg <= i_pwdata[4:0];
				default: ;
			endcase
		end
	end

	// Bus answer, read mux and interrupt pin
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0;
			o_irq     <= 1'b0;
		end else if (i_ce) begin
			o_irq     <= isr_code != `USF_ISR_NONE;
			o_pready  <= i_psel && i_penable && !o_pready;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0;
			if (rd_fire) begin
				case (i_paddr)
					`USF_A_DATA:   o_prdata[7:0] <= mem[rptr_reg];
					`USF_A_IER:    o_prdata[7:0] <= ier_reg;
					`USF_A_ISR:    o_prdata[7:0] <= isr_code;
					`USF_A_LCR:    o_prdata[7:0] <= lcr_reg;
					`USF_A_MCR:    o_prdata[7:0] <= mcr_reg;
					`USF_A_LSR:    o_prdata[7:0] <= {1'b0,
						tx_st_reg == usf_pkg::USF_IDLE && !thr_full_reg,
						!thr_full_reg, 4'h0, count_reg != 5'h0};
					`USF_A_DIVLO:  o_prdata[7:0] <= divlo_reg;
					`USF_A_DIVHI:  o_prdata[7:0] <= divhi_reg;
					`USF_A_FRAC:   o_prdata[3:0] <= frac_reg;
					`USF_A_EFR:    o_prdata[7:0] <= efr_reg;
					`USF_A_RES1:   o_prdata[7:0] <= res1_reg;
					`USF_A_RES2:   o_prdata[7:0] <= res2_reg;
					`USF_A_PAU1:   o_prdata[7:0] <= pau1_reg;
					`USF_A_PAU2:   o_prdata[7:0] <= pau2_reg;
					`USF_A_FLOWHI: o_prdata[4:0] <= flowhi_reg;
					`USF_A_FLOWLO: o_prdata[4:0] <= flowlo_reg;
					`USF_A_RXTRIG: o_prdata[4:0] <= rxtrig_reg;
					default:       o_prdata <= 32'h0;
				endcase
			end
			if (i_psel && i_penable && !o_pready) begin
				case (i_paddr)
					`USF_A_DATA, `USF_A_IER, `USF_A_ISR, `USF_A_LCR,
					`USF_A_MCR, `USF_A_LSR, `USF_A_DIVLO, `USF_A_DIVHI,
					`USF_A_FRAC, `USF_A_EFR, `USF_A_RES1, `USF_A_RES2,
					`USF_A_PAU1, `USF_A_PAU2, `USF_A_FLOWHI, `USF_A_FLOWLO,
					`USF_A_RXTRIG: o_pslverr <= 1'b0;
					default:       o_pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Receiver shift; stop bit taken at its centre
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rx_st_reg   <= usf_pkg::USF_IDLE;
			rx_t_reg    <= 4'h0;
			rx_b_reg    <= 3'h0;
			rx_sh_reg   <= 8'h00;
			rx_char_reg <= 8'h00;
			rx_done_reg <= 1'b0;
		end else if (i_ce) begin
			rx_done_reg <= 1'b0;
			if (tick) begin
				rx_t_reg <= rx_t_reg + 4'h1;
				case (rx_st_reg)
					usf_pkg::USF_IDLE: begin
						rx_t_reg <= 4'h0;
						if (!i_rx)
							rx_st_reg <= usf_pkg::USF_START;
					end
					usf_pkg::USF_START: begin
						if (rx_t_reg == `USF_MIDBIT) begin
							rx_t_reg  <= 4'h0;
							rx_b_reg  <= 3'h0;
							rx_st_reg <= i_rx ? usf_pkg::USF_IDLE
							                  : usf_pkg::USF_DATA;
						end
					end
					usf_pkg::USF_DATA: begin
						if (rx_t_reg == `USF_OVS) begin
							rx_sh_reg <= {i_rx, rx_sh_reg[7:1]};
							rx_b_reg  <= rx_b_reg + 3'h1;
							if ({1'b0, rx_b_reg} == nbits - 4'h1)
								rx_st_reg <= lcr_reg[`USF_LCR_PEN] ?
									usf_pkg::USF_PAR : usf_pkg::USF_STOP;
						end
					end
					usf_pkg::USF_PAR: begin
						if (rx_t_reg == `USF_OVS)
							rx_st_reg <= usf_pkg::USF_STOP;
					end
					usf_pkg::USF_STOP: begin
						if (rx_t_reg == `USF_OVS) begin
							rx_char_reg <= rx_sh_reg >> (2'h3 - lcr_reg[1:0]);
							rx_done_reg <= 1'b1;
							rx_st_reg   <= usf_pkg::USF_IDLE;
						end
					end
					default: rx_st_reg <= usf_pkg::USF_IDLE;
				endcase
			end
		end
	end

	// Flow character recognition on each received character
	always_comb begin
		push = 1'b0;
		push_data = rx_char_reg;
		act_pause = 1'b0;
		act_resume = 1'b0;
		hold_set = 1'b0;
		hold_clr = 1'b0;
		replay = 1'b0;
		spc_hit = 1'b0;
		if (rx_done_reg || replay_reg) begin
			spc_hit = efr_reg[`USF_EFR_SPC] && m_off2;
			case (efr_reg[1:0])
				2'h1: begin
					act_pause  = m_off1;
					act_resume = m_on1 && !m_off1;
					push       = !m_off1 && !m_on1;
				end
				2'h2: begin
					act_pause  = m_off2;
					act_resume = m_on2 && !m_off2;
					push       = !m_off2 && !m_on2;
				end
				2'h3: begin
					if (held_reg && held_on_reg && m_on2) begin
						act_resume = 1'b1;
						hold_clr   = 1'b1;
					end else if (held_reg && !held_on_reg && m_off2) begin
						act_pause = 1'b1;
						hold_clr  = 1'b1;
					end else if (held_reg) begin
						push      = 1'b1;
						push_data = held_char_reg;
						hold_clr  = 1'b1;
						replay    = 1'b1;
					end else if (m_off1 || m_on1) begin
						hold_set = 1'b1;
					end else begin
						push = 1'b1;
					end
				end
				default: push = 1'b1;
			endcase
		end
	end

	// Held first half of a pair; replay re-checks the newer character
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			held_reg      <= 1'b0;
			held_on_reg   <= 1'b0;
			held_char_reg <= 8'h00;
			replay_reg    <= 1'b0;
		end else if (i_ce) begin
			replay_reg <= replay;
			if (hold_set) begin
				held_reg      <= 1'b1;
				held_on_reg   <= m_on1 && !m_off1;
				held_char_reg <= rx_char_reg;
			end else if (hold_clr || efr_reg[1:0] != 2'h3) begin
				held_reg <= 1'b0;
			end
		end
	end

	// Receive FIFO; overflow drops the new character
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wptr_reg  <= 4'h0;
			rptr_reg  <= 4'h0;
			count_reg <= 5'h0;
		end else if (i_ce) begin
			if (push && count_reg != `USF_DEPTH) begin
				mem[wptr_reg] <= push_data;
				wptr_reg      <= wptr_reg + 4'h1;
			end
			if (pop)
				rptr_reg <= rptr_reg + 4'h1;
			count_reg <= count_reg
				+ {4'h0, push && count_reg != `USF_DEPTH}
				- {4'h0, pop};
		end
	end

	// Time-out length in ticks: four characters in half-bit units
	assign half_bits = 5'h2 + {nbits, 1'b0}
		+ {3'h0, lcr_reg[`USF_LCR_PEN], 1'b0}
		+ (!lcr_reg[`USF_LCR_STOP] ? 5'h2 :
		   lcr_reg[1:0] == 2'h0 ? 5'h3 : 5'h4);
	assign to_limit = {5'h0, half_bits} * `USF_TO_HALF * `USF_TO_CHARS;
	assign to_restart = rx_done_reg || pop;

	// Time-out counter, idle while FIFO empty
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			to_cnt_reg  <= 10'h0;
			to_flag_reg <= 1'b0;
		end else if (i_ce) begin
			if (to_restart || count_reg == 5'h0) begin
				to_cnt_reg  <= 10'h0;
				to_flag_reg <= 1'b0;
			end else if (tick && !to_flag_reg) begin
				to_cnt_reg <= to_cnt_reg + 10'h1;
				if (to_cnt_reg + 10'h1 >= to_limit)
					to_flag_reg <= 1'b1;
			end
		end
	end

	// Pause state, status bit 4 and transmit-empty source; set wins
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			paused_reg   <= 1'b0;
			spc_flag_reg <= 1'b0;
			thr_pend_reg <= 1'b0;
		end else if (i_ce) begin
			if (act_pause)
				paused_reg <= 1'b1;
			else if (act_resume || efr_reg[1:0] == 2'h0)
				paused_reg <= 1'b0;
			if (act_pause || spc_hit)
				spc_flag_reg <= 1'b1;
			else if (act_resume || (isr_rd && isr_code == `USF_ISR_SPC))
				spc_flag_reg <= 1'b0;
			if (tx_start_data || (wr_fire &&
			    i_paddr == `USF_A_IER && i_pwdata[`USF_IER_THR] &&
			    !ier_reg[`USF_IER_THR] && !thr_full_reg))
				thr_pend_reg <= 1'b1;
			else if ((wr_fire && i_paddr == `USF_A_DATA) ||
			         (isr_rd && isr_code == `USF_ISR_THR))
				thr_pend_reg <= 1'b0;
		end
	end

	// Transmit start choice: flow characters first, data when not paused
	assign tx_start_flow = tx_st_reg == usf_pkg::USF_IDLE &&
		flow_left_reg != 2'h0;
	assign tx_start_data = tx_st_reg == usf_pkg::USF_IDLE &&
		flow_left_reg == 2'h0 && thr_full_reg && !paused_reg;
	assign flow_char = (efr_reg[3:2] == 2'h1 ||
		(efr_reg[3:2] == 2'h3 && flow_left_reg == 2'h2)) ?
		(sent_pause_reg ? pau1_reg : res1_reg) :
		(sent_pause_reg ? pau2_reg : res2_reg);
	assign stop_ticks = !lcr_reg[`USF_LCR_STOP] ? 6'h10 :
		lcr_reg[1:0] == 2'h0 ? 6'h18 : 6'h20;

	// Holding register and pause or resume requests
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			thr_reg        <= 8'h00;
			thr_full_reg   <= 1'b0;
			sent_pause_reg <= 1'b0;
			flow_left_reg  <= 2'h0;
		end else if (i_ce) begin
			if (wr_fire && i_paddr == `USF_A_DATA) begin
				thr_reg      <= i_pwdata[7:0];
				thr_full_reg <= 1'b1;
			end else if (tx_start_data) begin
				thr_full_reg <= 1'b0;
			end
			if (tx_start_flow) begin
				flow_left_reg <= flow_left_reg - 2'h1;
			end else if (efr_reg[3:2] == 2'h0) begin
				sent_pause_reg <= 1'b0;
			end else if (flow_left_reg == 2'h0 && tx_st_reg ==
			             usf_pkg::USF_IDLE) begin
				if (!sent_pause_reg && count_reg > flowhi_reg) begin
					sent_pause_reg <= 1'b1;
					flow_left_reg  <= efr_reg[3:2] == 2'h3 ? 2'h2 : 2'h1;
				end else if (sent_pause_reg && count_reg < flowlo_reg) begin
					sent_pause_reg <= 1'b0;
					flow_left_reg  <= efr_reg[3:2] == 2'h3 ? 2'h2 : 2'h1;
				end
			end
		end
	end

	// Transmitter shift, LSB first
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			tx_st_reg   <= usf_pkg::USF_IDLE;
			tx_sh_reg   <= 8'h00;
			tx_b_reg    <= 3'h0;
			tx_tick_reg <= 6'h0;
			o_tx        <= 1'b1;
		end else if (i_ce) begin
			case (tx_st_reg)
				usf_pkg::USF_IDLE: begin
					o_tx        <= 1'b1;
					tx_tick_reg <= 6'h0;
					if (tx_start_flow || tx_start_data) begin
						tx_sh_reg <= (tx_start_flow ? flow_char : thr_reg) & mask;
						tx_st_reg <= usf_pkg::USF_START;
						o_tx      <= 1'b0;
					end
				end
				default: begin
					if (tick) begin
						tx_tick_reg <= tx_tick_reg + 6'h1;
						if (tx_st_reg == usf_pkg::USF_STOP ?
						    tx_tick_reg == stop_ticks - 6'h1 :
						    tx_tick_reg == 6'h0f) begin
							tx_tick_reg <= 6'h0;
							case (tx_st_reg)
								usf_pkg::USF_START: begin
									tx_st_reg <= usf_pkg::USF_DATA;
									tx_b_reg  <= 3'h0;
									o_tx      <= tx_sh_reg[0];
								end
								usf_pkg::USF_DATA: begin
									tx_b_reg <= tx_b_reg + 3'h1;
									if ({1'b0, tx_b_reg} == nbits - 4'h1) begin
										tx_st_reg <= lcr_reg[`USF_LCR_PEN] ?
											usf_pkg::USF_PAR : usf_pkg::USF_STOP;
										o_tx <= lcr_reg[`USF_LCR_PEN] ?
											((^tx_sh_reg) ~^ lcr_reg[`USF_LCR_EVEN])
											: 1'b1;
									end else begin
										o_tx <= tx_sh_reg[tx_b_reg + 3'h1];
									end
								end
								usf_pkg::USF_PAR: begin
									tx_st_reg <= usf_pkg::USF_STOP;
									o_tx      <= 1'b1;
								end
								default: tx_st_reg <= usf_pkg::USF_IDLE;
							endcase
						end
					end
				end
			endcase
		end
	end
endmodule

//--- shared/usf_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef USF_CONSTS_SVH
`define USF_CONSTS_SVH
// Byte addresses of the registers
`define USF_A_DATA    8'h00
`define USF_A_IER     8'h04
`define USF_A_ISR     8'h08
`define USF_A_LCR     8'h0c
`define USF_A_MCR     8'h10
`define USF_A_LSR     8'h14
`define USF_A_DIVLO   8'h18
`define USF_A_DIVHI   8'h1c
`define USF_A_FRAC    8'h20
`define USF_A_EFR     8'h24
`define USF_A_RES1    8'h28
`define USF_A_RES2    8'h2c
`define USF_A_PAU1    8'h30
`define USF_A_PAU2    8'h34
`define USF_A_FLOWHI  8'h38
`define USF_A_FLOWLO  8'h3c
`define USF_A_RXTRIG  8'h40
// Field positions
`define USF_IER_RX    0
`define USF_IER_THR   1
`define USF_IER_SPC   5
`define USF_EFR_SPC   5
`define USF_MCR_PRE   7
`define USF_LCR_STOP  2
`define USF_LCR_PEN   3
`define USF_LCR_EVEN  4
// Interrupt status codes
`define USF_ISR_NONE  8'h01
`define USF_ISR_RXTO  8'h0c
`define USF_ISR_RXD   8'h04
`define USF_ISR_THR   8'h02
`define USF_ISR_SPC   8'h10
// Reset values
`define USF_RST_CHAR  8'h00
`define USF_RST_DIVLO 8'h01
`define USF_RST_DIVHI 8'h00
`define USF_RST_LCR   8'h03
`define USF_RST_FLOWHI 5'h0c
`define USF_RST_FLOWLO 5'h04
`define USF_RST_RXTRIG 5'h01
// FIFO depth and timing
`define USF_DEPTH     5'h10
`define USF_OVS       4'hf
`define USF_MIDBIT    4'h7
`define USF_TO_CHARS  10'h004
`define USF_TO_HALF   10'h008
`endif

//--- shared/usf_pkg.sv
// Types shared by the serial core
package usf_pkg;
	typedef enum logic [2:0] {
		USF_IDLE,
		USF_START,
		USF_DATA,
		USF_PAR,
		USF_STOP
	} usf_ser_state_t;
endpackage

//--- core/usf_baud_gen.sv
// Fractional baud generator producing the 16x sample tick
`timescale 1ns/100ps
`include "usf_consts.svh"
module usf_baud_gen (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_ce,
	// Rate setting
	input  wire logic [15:0] i_divisor,
	input  wire logic [3:0]  i_frac,
	input  wire logic        i_presc4,
	// Tick out
	output logic             o_tick16
);
	logic [1:0]  pre_reg;
	logic [16:0] cnt_reg;
	logic [3:0]  acc_reg;
	logic        pre_tick;
	logic [4:0]  frac_sum;

	// Prescale by 1 or by 4
	assign pre_tick = !i_presc4 || (pre_reg == 2'h3);
	assign frac_sum = {1'b0, acc_reg} + {1'b0, i_frac};

	// Prescale counter
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pre_reg <= 2'h0;
		end else if (i_ce) begin
			pre_reg <= pre_reg + 2'h1;
		end
	end

	// N or N+1 periods, the extra one M times in sixteen
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt_reg  <= 17'h0;
			acc_reg  <= 4'h0;
			o_tick16 <= 1'b0;
		end else if (i_ce) begin
			o_tick16 <= 1'b0;
			if (pre_tick && i_divisor != 16'h0) begin
				if (cnt_reg <= 17'h1) begin
					o_tick16 <= 1'b1;
					acc_reg  <= frac_sum[3:0];
					cnt_reg  <= frac_sum[4] ? {1'b0, i_divisor} + 17'h1
					                        : {1'b0, i_divisor};
				end else begin
					cnt_reg <= cnt_reg - 17'h1;
				end
			end
		end
	end
endmodule

//--- tb/usf_uart_checker.sv
// Port-level checks of the serial core bus and line
`timescale 1ns/100ps
module usf_uart_checker (
	// Clock, reset, enable
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_ce,
	// Bus and line
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_tx,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Reset itself is the cause here, so no disable
	a_reset_idle: assert property (disable iff (1'b0)
		i_reset && i_ce |=> o_tx && !o_irq && !o_pready)
		else $error("outputs not idle in reset");
	a_one_wait: assert property (
		i_ce && i_psel && i_penable && !o_pready |=> o_pready)
		else $error("answer not after one wait");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_unmapped_err: assert property (i_psel && i_penable
		&& !o_pready && i_paddr > 8'h40
		|=> o_pslverr && o_prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (i_psel && i_penable && !o_pready
		&& i_paddr <= 8'h40 && i_paddr[1:0] == 2'h0 |=> !o_pslverr)
		else $error("mapped access refused");
	a_no_stray: assert property (!(i_psel && i_penable) |=> !o_pready)
		else $error("ready without access");
	a_upper_zero: assert property (o_pready && !i_pwrite
		|-> o_prdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	// Shortest bit is sixteen clocks at divisor one
	a_start_len: assert property ($fell(o_tx) |=> !o_tx [*8])
		else $error("start bit too short");
endmodule

bind usf_uart usf_uart_checker usf_uart_checker_inst (
	.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_tx(o_tx), .o_irq(o_irq)
);

//--- tb/usf_remote.sv
// Remote serial partner: sends frames, collects frames
`timescale 1ns/100ps
module usf_remote (
	// Clock and bit length in clocks
	input  wire logic        i_clk,
	input  wire logic [15:0] i_bit,
	// Serial line
	input  wire logic        i_line_in,
	output logic             o_line_out
);
	logic [7:0] got_q[$];
	logic [7:0] sh;
	initial o_line_out = 1'b1;
	// Start, eight data bits LSB first, stop, then idle high
	task automatic send(input logic [7:0] ch);
		for (int b = 0; b < 10; b++) begin
			o_line_out <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : ch[b-1];
			repeat (i_bit) @(posedge i_clk);
		end
	endtask
	// Mid-bit sampling; a wrong rate shifts the bits seen
	always begin
		@(negedge i_line_in);
		repeat (i_bit / 2) @(posedge i_clk);
		for (int b = 0; b < 8; b++) begin
			repeat (i_bit) @(posedge i_clk);
			sh[b] = i_line_in;
		end
		repeat (i_bit) @(posedge i_clk);
		got_q.push_back(sh);
	end
endmodule

//--- tb/usf_uart_bench.sv
// Self-checking bench for the serial core
`timescale 1ns/100ps
`include "usf_consts.svh"
module usf_uart_bench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx;
	logic        tx;
	logic        irq;
	logic [15:0] bitc = 16'h0010;
	logic [31:0] rd;
	logic        err;
	int          fails = 0;
	int          n_tests = 0;
	// Reset-value table
	logic [7:0]  ra[10] = '{`USF_A_RES1, `USF_A_RES2, `USF_A_PAU1,
		`USF_A_PAU2, `USF_A_DIVLO, `USF_A_DIVHI, `USF_A_LCR,
		`USF_A_FLOWHI, `USF_A_FLOWLO, `USF_A_ISR};
	logic [7:0]  re[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
		8'h00, 8'h03, 8'h0c, 8'h04, 8'h01};
	// Rate table: low, fraction, modem control, clocks per bit
	logic [7:0]  bl[3] = '{8'h03, 8'h02, 8'h01};
	logic [7:0]  bm[3] = '{8'h00, 8'h08, 8'h00};
	logic [7:0]  bp[3] = '{8'h00, 8'h00, 8'h80};
	logic [15:0] bc[3] = '{16'h0030, 16'h0028, 16'h0040};

	always #12.5 clk = ~clk;

	usf_uart usf_uart_inst (
		.i_clk(clk), .i_reset(rst), .i_ce(ce),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_rx(rx), .o_tx(tx), .o_irq(irq)
	);
	usf_remote usf_remote_inst (
		.i_clk(clk), .i_bit(bitc), .i_line_in(tx), .o_line_out(rx)
	);

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	// One transfer; a release edge passes before the next setup
	task automatic apb(input logic w, input logic [7:0] a, d);
		int n;
		n = 0;
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		rd  = prdata;
		err = pslverr;
		if (n >= 20) fails++;
		psel <= 1'b0;
		pen  <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), e, rd);
	endtask
	task automatic dr(input logic e);
		apb(1'b0, `USF_A_LSR, 8'h00);
		chk("data ready", {31'h0, e}, {31'h0, rd[0]});
	endtask
	// Bounded wait for a frame at the partner
	task automatic got(input logic [7:0] e);
		int n;
		n = 0;
		while (usf_remote_inst.got_q.size() == 0 && n++ < 3000)
			@(posedge clk);
		chk("tx char", {24'h0, e}, (n > 3000) ? 32'hx :
			{24'h0, usf_remote_inst.got_q.pop_front()});
	endtask
	task automatic end_of_test();
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 10; i++) rc(ra[i], re[i]);
		apb(1'b0, 8'h44, 8'h00);
		chk("unmapped err", 1, {31'h0, err});
		// Both sources pending: receive outranks transmit-empty
		apb(1'b1, `USF_A_IER, 8'h03);
		chk("irq", 1, {31'h0, irq});
		usf_remote_inst.send(8'h3c);
		repeat (40) @(posedge clk);
		rc(`USF_A_ISR, 8'h04);
		rc(`USF_A_DATA, 8'h3c);
		rc(`USF_A_ISR, 8'h02);
		rc(`USF_A_ISR, 8'h01);
		dr(1'b0);
		// One character below trigger two: only the time-out fires
		apb(1'b1, `USF_A_RXTRIG, 8'h02);
		usf_remote_inst.send(8'h55);
		// Frozen span must not count toward the time-out
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		ce <= 1'b1;
		repeat (600) @(posedge clk);
		rc(`USF_A_ISR, 8'h01);
		repeat (36) @(posedge clk);
		rc(`USF_A_ISR, 8'h0c);
		rc(`USF_A_DATA, 8'h55);
		rc(`USF_A_ISR, 8'h01);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `USF_A_DIVLO, bl[i]);
			apb(1'b1, `USF_A_FRAC, bm[i]);
			apb(1'b1, `USF_A_MCR, bp[i]);
			bitc <= bc[i];
			apb(1'b1, `USF_A_DATA, 8'hc3);
			got(8'hc3);
			usf_remote_inst.send(8'h96);
			rc(`USF_A_DATA, 8'h96);
		end
		apb(1'b1, `USF_A_DIVLO, 8'h01);
		apb(1'b1, `USF_A_FRAC, 8'h00);
		apb(1'b1, `USF_A_MCR, 8'h00);
		bitc <= 16'h0010;
		// Pause and resume characters in both directions
		apb(1'b1, `USF_A_PAU1, 8'h13);
		apb(1'b1, `USF_A_RES1, 8'h11);
		apb(1'b1, `USF_A_FLOWHI, 8'h02);
		apb(1'b1, `USF_A_FLOWLO, 8'h01);
		apb(1'b1, `USF_A_IER, 8'h20);
		apb(1'b1, `USF_A_EFR, 8'h05);
		usf_remote_inst.send(8'h13);
		repeat (20) @(posedge clk);
		dr(1'b0);
		rc(`USF_A_ISR, 8'h10);
		apb(1'b1, `USF_A_DATA, 8'h77);
		repeat (300) @(posedge clk);
		chk("held", 0, usf_remote_inst.got_q.size());
		usf_remote_inst.send(8'h11);
		got(8'h77);
		rc(`USF_A_ISR, 8'h01);
		// Payload kept clear of the flow characters
		for (int i = 1; i < 4; i++) usf_remote_inst.send(8'ha0 + i[7:0]);
		got(8'h13);
		rc(`USF_A_DATA, 8'ha1);
		rc(`USF_A_DATA, 8'ha2);
		chk("no resume", 0, usf_remote_inst.got_q.size());
		rc(`USF_A_DATA, 8'ha3);
		got(8'h11);
		// Pairs: pause only after both halves arrive
		apb(1'b1, `USF_A_PAU2, 8'h14);
		apb(1'b1, `USF_A_RES2, 8'h12);
		apb(1'b1, `USF_A_EFR, 8'h03);
		usf_remote_inst.send(8'h13);
		usf_remote_inst.send(8'h14);
		apb(1'b1, `USF_A_DATA, 8'h66);
		repeat (300) @(posedge clk);
		chk("pair held", 0, usf_remote_inst.got_q.size());
		usf_remote_inst.send(8'h11);
		usf_remote_inst.send(8'h12);
		got(8'h66);
		dr(1'b0);
		// Seven-bit special match ignores the eighth stored bit
		apb(1'b1, `USF_A_EFR, 8'h20);
		apb(1'b1, `USF_A_LCR, 8'h02);
		apb(1'b1, `USF_A_PAU2, 8'hda);
		usf_remote_inst.send(8'h5a);
		repeat (20) @(posedge clk);
		rc(`USF_A_ISR, 8'h10);
		rc(`USF_A_DATA, 8'h5a);
		end_of_test();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		end_of_test();
	end
endmodule
